//--- include/fwsig_pkg.sv
// Constants for the flash wait-state and signature controller.
// Assumes a 50 MHz system clock and a plain register port with byte addresses.
package fwsig_pkg;
   // Register byte offsets
   localparam logic [11:0] ADDR_TIMING_CFG = 12'h010;
   localparam logic [11:0] ADDR_SIG_FIRST  = 12'h020;
   localparam logic [11:0] ADDR_SIG_LAST   = 12'h024;
   localparam logic [11:0] ADDR_SIG_W0     = 12'h02C;
   localparam logic [11:0] ADDR_SIG_W1     = 12'h030;
   localparam logic [11:0] ADDR_SIG_W2     = 12'h034;
   localparam logic [11:0] ADDR_SIG_W3     = 12'h038;
   localparam logic [11:0] ADDR_IRQ_MASK   = 12'h040;
   localparam logic [11:0] ADDR_STATUS     = 12'hFE0;
   localparam logic [11:0] ADDR_STATUS_CLR = 12'hFE8;
   // Field layout
   localparam int          ACC_LSB         = 0;
   localparam int          ACC_W           = 2;
   localparam logic [1:0]  ACC_RESET       = 2'h2;
   localparam int          WADDR_W         = 17;
   localparam int          LAUNCH_BIT      = 17;
   localparam int          DONE_BIT        = 2;
   localparam int          SIG_W           = 128;
   // Self-timed signature read: 60 ns per word plus 3 cycles
   localparam int          CLK_PERIOD_NS   = 20;
   localparam int          SIG_READ_NS     = 60;
   localparam int          SIG_WORD_CYC    = SIG_READ_NS / CLK_PERIOD_NS + 3;
   localparam int          SIG_RD_CYC      = (SIG_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Signature feedback taps
   localparam int          TAP_A           = 0;
   localparam int          TAP_B           = 2;
   localparam int          TAP_C           = 27;
   localparam int          TAP_D           = 29;
endpackage

//--- rtl/fwsig_ctrl.sv
// Flash read timing and signature generator controller.
// Assumes a flash read port that returns data SIG_RD_CYC cycles after a request,
// and a single-cycle register port with read data in the following cycle.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Access field in timing config bits 1:0; read takes field plus one clocks; reset 10
// - Codes 0,1,2 give one, two, three clocks; code 3 reserved
// - First-word register holds 17-bit word address, reset zero
// - Last-word register holds 17-bit word address, reset zero
// - Bit 17 of last-word register launches generation when the sequencer is idle (ignored during a run or system read); reset zero
// - Launch uses the last address written in the same access
// - Signature read as four words, low word first
// - Status bit 2 shows generation finished; reset zero
// - Writing one to clear bit 2 clears completion; zero does nothing
// - Reserved bits not written with ones; they read as zero here
// - Signature shifts right, feedback taps 0, 2, 27, 29 into bit 127
// - Other flash reads wait while generation runs
// - Each word takes at most int(60/tcy+3) cycles
module fwsig_ctrl #(
   parameter int AW = fwsig_pkg::WADDR_W,
   parameter int DW = fwsig_pkg::SIG_W
) (
   // Clock and reset
   input  wire logic          i_clk,
   input  wire logic          i_resetn,
   // Register port
   input  wire logic [11:0]   i_addr,
   input  wire logic [31:0]   i_wdata,
   input  wire logic          i_wr,
   input  wire logic          i_rd,
   output logic      [31:0]   o_rdata,
   // System read request into flash
   input  wire logic          i_sys_req,
   input  wire logic [AW-1:0] i_sys_addr,
   output logic               o_sys_wait,
   output logic               o_sys_valid,
   output logic      [DW-1:0] o_sys_data,
   // Flash array read port
   output logic               o_fl_req,
   output logic      [AW-1:0] o_fl_addr,
   input  wire logic [DW-1:0] i_fl_data,
   // Interrupt
   output logic               o_irq
);
   typedef enum logic [1:0] {FW_IDLE, FW_SYS, FW_SIG} fw_state_t;

   fw_state_t          state;
   logic [1:0]         access_cycle_field;
   logic [AW-1:0]      first_word;
   logic [AW-1:0]      last_word;
   logic [AW-1:0]      cur_word;
   logic               generation_launch;
   logic               generation_complete;
   logic               irq_mask;
   logic [2:0]         cnt;
   logic               sig_clear;
   logic               sig_fold;
   logic [DW-1:0]      sig;
   logic               wr_last;
   logic               launch_req;
   logic               clr_req;
   logic               done_evt;
   logic [2:0]         sys_cyc;

   function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
      return a == r;
   endfunction

   assign wr_last    = i_wr && hit(i_addr, fwsig_pkg::ADDR_SIG_LAST);
   // Launch and last address come from the same write, so the run uses that address
   assign launch_req = wr_last && i_wdata[fwsig_pkg::LAUNCH_BIT];
   assign clr_req    = i_wr && hit(i_addr, fwsig_pkg::ADDR_STATUS_CLR)
                       && i_wdata[fwsig_pkg::DONE_BIT];
   // Access field counts extra cycles; code 3 is treated as three clocks
   assign sys_cyc    = (access_cycle_field == 2'h3) ? 3'h2 : {1'b0, access_cycle_field};

   // Timing config
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         access_cycle_field <= fwsig_pkg::ACC_RESET;
      end else if (i_wr && hit(i_addr, fwsig_pkg::ADDR_TIMING_CFG)) begin
         access_cycle_field <= i_wdata[fwsig_pkg::ACC_LSB +: fwsig_pkg::ACC_W];
      end
   end

   // Address range registers
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         first_word <= '0;
         last_word  <= '0;
      end else begin
         if (i_wr && hit(i_addr, fwsig_pkg::ADDR_SIG_FIRST)) begin
            first_word <= i_wdata[AW-1:0];
         end
         if (wr_last) begin
            last_word <= i_wdata[AW-1:0];
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_mask <= 1'b0;
      end else if (i_wr && hit(i_addr, fwsig_pkg::ADDR_IRQ_MASK)) begin
         irq_mask <= i_wdata[fwsig_pkg::DONE_BIT];
      end
   end

   // Completion flag: a finishing run wins over a clear in the same cycle
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         generation_complete <= 1'b0;
      end else if (done_evt) begin
         generation_complete <= 1'b1;
      end else if (clr_req) begin
         generation_complete <= 1'b0;
      end
   end

   assign o_irq = generation_complete & irq_mask;

   // Sequencer: signature words are self-timed, system reads use the access field
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state             <= FW_IDLE;
         cnt               <= 3'h0;
         cur_word          <= '0;
         generation_launch <= 1'b0;
      end else begin
         unique case (state)
            FW_IDLE: begin
               cnt <= 3'h0;
               if (launch_req) begin
                  state             <= FW_SIG;
                  cur_word          <= first_word;
                  generation_launch <= 1'b1;
               end else if (i_sys_req) begin
                  state <= FW_SYS;
               end
            end
            FW_SYS: begin
               if (cnt == sys_cyc) begin
                  state <= FW_IDLE;
                  cnt   <= 3'h0;
               end else begin
                  cnt <= cnt + 3'h1;
               end
            end
            FW_SIG: begin
               if (cnt == 3'(fwsig_pkg::SIG_RD_CYC - 1)) begin
                  cnt <= 3'h0;
                  if (cur_word == last_word) begin
                     state             <= FW_IDLE;
                     generation_launch <= 1'b0;
                  end else begin
                     cur_word <= cur_word + 1'b1;
                  end
               end else begin
                  cnt <= cnt + 3'h1;
               end
            end
            default: begin
               state <= FW_IDLE;
            end
         endcase
      end
   end

   assign sig_clear = launch_req && (state == FW_IDLE);
   assign sig_fold  = (state == FW_SIG) && (cnt == 3'(fwsig_pkg::SIG_RD_CYC - 1));
   assign done_evt  = sig_fold && (cur_word == last_word);
   assign o_fl_req  = (state == FW_SIG) || (state == FW_SYS);
   assign o_fl_addr = (state == FW_SIG) ? cur_word : i_sys_addr;
   // Hold the system master off during generation and until its read completes
   assign o_sys_wait = i_sys_req && !((state == FW_SYS) && (cnt == sys_cyc));

   // System read data
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sys_valid <= 1'b0;
         o_sys_data  <= '0;
      end else begin
         o_sys_valid <= (state == FW_SYS) && (cnt == sys_cyc);
         if ((state == FW_SYS) && (cnt == sys_cyc)) begin
            o_sys_data <= i_fl_data;
         end
      end
   end

   fwsig_misr #(
      .W(DW)
   ) u_misr (
      .i_clk   (i_clk),
      .i_resetn(i_resetn),
      .i_clear (sig_clear),
      .i_fold  (sig_fold),
      .i_word  (i_fl_data),
      .o_sig   (sig)
   );

   // Register read; reserved bits read as zero
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata <= 32'h0;
      end else if (i_rd) begin
         unique case (i_addr)
            fwsig_pkg::ADDR_TIMING_CFG: o_rdata <= {30'h0, access_cycle_field};
            fwsig_pkg::ADDR_SIG_FIRST:  o_rdata <= {15'h0, first_word};
            fwsig_pkg::ADDR_SIG_LAST:   o_rdata <= {14'h0, generation_launch, last_word};
            fwsig_pkg::ADDR_SIG_W0:     o_rdata <= sig[31:0];
            fwsig_pkg::ADDR_SIG_W1:     o_rdata <= sig[63:32];
            fwsig_pkg::ADDR_SIG_W2:     o_rdata <= sig[95:64];
            fwsig_pkg::ADDR_SIG_W3:     o_rdata <= sig[127:96];
            fwsig_pkg::ADDR_IRQ_MASK:   o_rdata <= {29'h0, irq_mask, 2'h0};
            fwsig_pkg::ADDR_STATUS:     o_rdata <= {29'h0, generation_complete, 2'h0};
            default:                    o_rdata <= 32'h0;
         endcase
      end else begin
         o_rdata <= 32'h0;
      end
   end
endmodule
`default_nettype wire

//--- rtl/fwsig_misr.sv
// 128-bit signature register folding one flash word per update.
// Assumes the caller pulses i_clear before the first word of a run.
`timescale 1ns/1ps
`default_nettype none
module fwsig_misr #(
   parameter int W = fwsig_pkg::SIG_W
) (
   // Clock and reset
   input  wire logic         i_clk,
   input  wire logic         i_resetn,
   // Control
   input  wire logic         i_clear,
   input  wire logic         i_fold,
   input  wire logic [W-1:0] i_word,
   // Result
   output logic      [W-1:0] o_sig
);
   logic [W-1:0] next_sig;

   always_comb begin
      next_sig = i_word ^ {1'b0, o_sig[W-1:1]};
      next_sig[W-1] = i_word[W-1] ^ o_sig[fwsig_pkg::TAP_A] ^ o_sig[fwsig_pkg::TAP_B]
                      ^ o_sig[fwsig_pkg::TAP_C] ^ o_sig[fwsig_pkg::TAP_D];
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_sig <= '0;
      end else if (i_clear) begin
         o_sig <= '0;
      end else if (i_fold) begin
         o_sig <= next_sig;
      end
   end
endmodule
`default_nettype wire

//--- sim/fwsig_ctrl_asserts.sv
// Port-level checks for the flash timing and signature controller.
// Assumes one clock domain and the asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module fwsig_ctrl_asserts #(
   parameter int AW = 17,
   parameter int DW = 128
) (
   input wire logic          i_clk,
   input wire logic          i_resetn,
   input wire logic [11:0]   i_addr,
   input wire logic [31:0]   i_wdata,
   input wire logic          i_wr,
   input wire logic          i_rd,
   input wire logic [31:0]   o_rdata,
   input wire logic          i_sys_req,
   input wire logic [AW-1:0] i_sys_addr,
   input wire logic          o_sys_wait,
   input wire logic          o_sys_valid,
   input wire logic [DW-1:0] o_sys_data,
   input wire logic          o_fl_req,
   input wire logic [AW-1:0] o_fl_addr,
   input wire logic [DW-1:0] i_fl_data,
   input wire logic          o_irq
);
   localparam int WORD_MAX = fwsig_pkg::SIG_WORD_CYC;
   logic [7:0]    same_cnt;
   logic [AW-1:0] prev_addr;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   // Cycles spent on one flash word
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         same_cnt <= '0;
         prev_addr <= '0;
      end else begin
         prev_addr <= o_fl_addr;
         same_cnt <= (o_fl_req && o_fl_addr == prev_addr) ? same_cnt + 8'h01 : 8'h00;
      end
   end
   rdata_idle_a: assert property (!i_rd |=> o_rdata == 32'h0)
      else $error("read data not zero outside a read");
   stat_resv_a: assert property (i_rd && i_addr == fwsig_pkg::ADDR_STATUS |=>
      o_rdata[31:3] == '0 && o_rdata[1:0] == 2'h0) else $error("status reserved bits set");
   clr_drop_a: assert property (i_wr && i_addr == fwsig_pkg::ADDR_STATUS_CLR &&
      i_wdata[2] && !o_fl_req |=> !o_irq) else $error("completion not cleared");
   launch_busy_a: assert property (i_wr && i_addr == fwsig_pkg::ADDR_SIG_LAST &&
      i_wdata[17] && !o_fl_req |=> o_fl_req [*3]) else $error("launch did not read flash");
   gen_stall_a: assert property ($rose(i_sys_req) && $past(o_fl_req) |-> o_sys_wait)
      else $error("read not stalled while flash busy");
   wait_idle_a: assert property (!i_sys_req |-> !o_sys_wait)
      else $error("wait without request");
   sys_lat_a: assert property ($rose(i_sys_req) && !$past(o_fl_req) && !$past(i_wr)
      |-> ##[1:4] o_sys_valid) else $error("system read too slow");
   word_time_a: assert property (same_cnt < WORD_MAX)
      else $error("flash word took too long");
endmodule
bind fwsig_ctrl fwsig_ctrl_asserts #(.AW(AW), .DW(DW)) u_chk (.i_clk(i_clk),
   .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .o_rdata(o_rdata), .i_sys_req(i_sys_req), .i_sys_addr(i_sys_addr),
   .o_sys_wait(o_sys_wait), .o_sys_valid(o_sys_valid), .o_sys_data(o_sys_data),
   .o_fl_req(o_fl_req), .o_fl_addr(o_fl_addr), .i_fl_data(i_fl_data), .o_irq(o_irq));
`default_nettype wire

//--- sim/fwsig_flash_model.sv
// Behavioural flash array read port: data is a pattern of the word address.
// Assumes the controller holds address steady while its request is high.
`timescale 1ns/1ps
`default_nettype none
module fwsig_flash_model (
   // Flash side of the controller
   input  wire logic         i_clk,
   input  wire logic         i_req,
   input  wire logic [16:0]  i_addr,
   output logic      [127:0] o_data
);
   logic [127:0] held = '0;
   // Self-timed array: valid data whenever a read is requested
   always_ff @(posedge i_clk) begin
      if (i_req) begin
         held <= o_data;
      end
   end
   // Idle bus shows the inverse of the last word, never a stale copy
   assign o_data = i_req ? {4{8'hC3, 7'h00, i_addr}} : ~held;
endmodule
`default_nettype wire

//--- sim/tb.sv
// Register-level bench for the flash timing and signature controller.
// Assumes the flash model pattern and the package register map.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic         i_clk = 1'b0;
   logic         i_resetn = 1'b0;
   logic [11:0]  i_addr = '0;
   logic [31:0]  i_wdata = '0;
   logic         i_wr = 1'b0;
   logic         i_rd = 1'b0;
   logic         i_sys_req = 1'b0;
   logic [16:0]  i_sys_addr = '0;
   logic [31:0]  o_rdata;
   logic         o_sys_wait, o_sys_valid, o_fl_req, o_irq;
   logic [127:0] o_sys_data, fl_data, sig, w;
   logic [16:0]  o_fl_addr;
   int           fail_count = 0;
   int           cmp_count = 0;
   int           n;
   always #10 i_clk = ~i_clk;
   fwsig_ctrl uut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_sys_req(i_sys_req),
      .i_sys_addr(i_sys_addr), .o_sys_wait(o_sys_wait), .o_sys_valid(o_sys_valid),
      .o_sys_data(o_sys_data), .o_fl_req(o_fl_req), .o_fl_addr(o_fl_addr),
      .i_fl_data(fl_data), .o_irq(o_irq));
   fwsig_flash_model u_fl (.i_clk(i_clk), .i_req(o_fl_req), .i_addr(o_fl_addr),
      .o_data(fl_data));
   function automatic logic [127:0] wd(input logic [16:0] a);
      return {4{8'hC3, 7'h00, a}};
   endfunction
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 chk(o_rdata, exp);
   endtask
   // Hold the flash read until the wait drops, then take the data pulse
   task automatic sys_done(input logic [16:0] a);
      n = 0;
      while (o_sys_wait && n < 40) begin
         @(posedge i_clk);
         #1 n++;
      end
      i_sys_req <= 1'b0;
      @(posedge i_clk);
      #1 chk(o_sys_valid, 1'b1);
      chk(o_sys_data, wd(a));
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #100us;
      fail_count++;
      wrap_up;
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      rd(fwsig_pkg::ADDR_TIMING_CFG, 32'h2);
      rd(fwsig_pkg::ADDR_SIG_FIRST, 32'h0);
      rd(fwsig_pkg::ADDR_SIG_LAST, 32'h0);
      rd(fwsig_pkg::ADDR_STATUS, 32'h0);
      rd(12'h100, 32'h0);
      $display("test reset done");
      for (int c = 0; c < 4; c++) begin
         wr(fwsig_pkg::ADDR_TIMING_CFG, 32'(c)); // reserved bits read back as zero
         rd(fwsig_pkg::ADDR_TIMING_CFG, 32'(c));
         @(posedge i_clk);
         i_sys_req <= 1'b1;
         i_sys_addr <= 17'(40 + c);
         @(posedge i_clk);
         #1 sys_done(17'(40 + c));
         chk(128'(n), 128'((c == 3) ? 2 : c));
      end
      $display("test timing done");
      wr(fwsig_pkg::ADDR_IRQ_MASK, 32'h4);
      wr(fwsig_pkg::ADDR_SIG_FIRST, 32'h3);
      rd(fwsig_pkg::ADDR_SIG_FIRST, 32'h3);
      wr(fwsig_pkg::ADDR_STATUS_CLR, 32'h4);
      wr(fwsig_pkg::ADDR_SIG_LAST, 32'h0002_0005);
      i_sys_req <= 1'b1;
      i_sys_addr <= 17'h9;
      sig = '0;
      for (int a = 3; a <= 5; a++) begin
         w = wd(17'(a));
         sig = {w[127] ^ sig[0] ^ sig[2] ^ sig[27] ^ sig[29], w[126:0] ^ sig[127:1]};
      end
      n = 0;
      while (o_irq !== 1'b1 && n < 40) begin
         @(posedge i_clk);
         #1 n++;
         if (o_irq !== 1'b1) chk(o_sys_wait, 1'b1);
      end
      chk(128'(n <= 3 * fwsig_pkg::SIG_WORD_CYC), 128'h1);
      sys_done(17'h9);
      for (int i = 0; i < 4; i++) begin
         rd(fwsig_pkg::ADDR_SIG_W0 + 12'(4 * i), sig[32 * i +: 32]);
      end
      rd(fwsig_pkg::ADDR_STATUS, 32'h4);
      wr(fwsig_pkg::ADDR_STATUS_CLR, 32'h0);
      rd(fwsig_pkg::ADDR_STATUS, 32'h4);
      chk(o_irq, 1'b1);
      wr(fwsig_pkg::ADDR_STATUS_CLR, 32'h4);
      rd(fwsig_pkg::ADDR_STATUS, 32'h0);
      chk(o_irq, 1'b0);
      rd(fwsig_pkg::ADDR_STATUS_CLR, 32'h0);
      $display("test signature done");
      wrap_up;
   end
endmodule
`default_nettype wire
